// >>> common/rfoc_pkg.sv
// rfoc_pkg: constants and types for the rf operating mode control block.
// assumes an 8-bit register port with 6-bit addresses and a 125 MHz mclk.
package rfoc_pkg;

  // register addresses
  localparam logic [5:0] ADDR_OP_CTRL = 6'h00;
  localparam logic [5:0] ADDR_IO_CFG1 = 6'h01;
  localparam logic [5:0] ADDR_IO_CFG2 = 6'h02;
  localparam logic [5:0] ADDR_AUX_DEF = 6'h03;
  localparam logic [5:0] ADDR_MODE    = 6'h04;
  localparam logic [5:0] ADDR_NORM    = 6'h05;
  localparam logic [5:0] ADDR_AM_LVL  = 6'h06;
  localparam logic [5:0] ADDR_DEPTH   = 6'h07;
  localparam logic [5:0] ADDR_STATUS  = 6'h08;
  localparam logic [5:0] ADDR_CMD     = 6'h09;

  // operation control fields
  localparam int OP_OSC_EN  = 7;
  localparam int OP_RX_EN   = 6;
  localparam int OP_RX_CHN  = 5;
  localparam int OP_RX_MAN  = 4;
  localparam int OP_TX_EN   = 3;
  localparam int OP_WAKE    = 2;
  // io configuration fields
  localparam int IO1_SINGLE = 7;
  localparam int IO1_OUTSEL = 6;
  localparam int IO2_SLOW   = 7;
  // auxiliary definition fields
  localparam int AUX_MODTYPE = 5;
  localparam int AUX_FASTOOK = 4;
  localparam int AUX_CHSEL   = 3;
  // status fields
  localparam int ST_OSC     = 0;
  localparam int ST_WAKE    = 1;
  localparam int ST_CAL     = 2;

  // reset values
  localparam logic [7:0] RST_OP    = 8'h00;
  localparam logic [7:0] RST_IO1   = 8'h00;
  localparam logic [7:0] RST_IO2   = 8'h00;
  localparam logic [7:0] RST_AUX   = 8'h00;
  localparam logic [7:0] RST_MODE  = 8'h00;
  localparam logic [7:0] RST_NORM  = 8'hff;
  localparam logic [7:0] RST_AM    = 8'h0f;
  localparam logic [7:0] RST_DEPTH = 8'h80;

  // direct command codes
  localparam logic [7:0] CMD_PRESET = 8'hcc;
  localparam logic [7:0] CMD_MASK   = 8'hd0;
  localparam logic [7:0] CMD_UNMASK = 8'hd1;
  localparam logic [7:0] CMD_CAL    = 8'hdd;

  // framing modes seen by the analog preset
  localparam logic [1:0] MODE_OOK = 2'h0;
  localparam logic [1:0] MODE_AM  = 2'h1;

  // timing
  localparam int CLK_MHZ      = 125;
  localparam int RAMP_STEP_NS = 80;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int CAL_SETTLE_NS = 200;
  localparam int CAL_SETTLE_CYC = (CAL_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_PERIOD_CYC = 12500;

  typedef struct packed {
    logic [7:0] seg;
    logic       level;
    logic       oe;
  } rfoc_drv_t;

endpackage

// >>> hw/rfoc_core.sv
// rfoc_core: operating modes, driver and receiver on/off control.
// assumes the register port is on mclk; analog status pins are asynchronous.
//
// Summary of operation
// - power-up clears the operation control register, giving power-down
// - register port keeps working in power-down so all settings load
// - oscillator enable bit starts oscillator and regulators: ready mode
// - oscillator stable raises an interrupt to the controller
// - receiver and transmitter enables act independently
// - wake bit alone enters wake-up mode with periodic timed measurements
// - in wake-up mode a measurement differing from reference interrupts
// - single-driver bit runs only one output driver
// - eight weighted segments; normal level register selects, default all
// - in single mode the output select bit picks the driving output
// - modulation type bit picks am or ook; analog preset sets it
// - ook holds driver state from just before the modulation interval
// - fast ook decay bit tristates drivers during ook modulation
// - am modulation enables fewer segments during the interval
// - calibrate command trims am level toward the target depth
// - slow ramp collapses driver supply while tx off, ramps when enabled
// - channel count bit makes both am and pm channels active or one
// - with both channels, manual bit picks manual or automatic choice
// - receive window goes high when the mask receive timer expires
// - mask and unmask commands force the receive window low or high
// - receive window gates rssi, agc and framing receive processing
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module rfoc_core #(
  parameter int WAKE_PERIOD = rfoc_pkg::WAKE_PERIOD_CYC
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [5:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_we,
  input  wire logic             reg_re,
  output logic [7:0]            reg_rdata,
  input  wire logic             osc_stable,
  input  wire logic             carrier_in,
  input  wire logic             meas_done,
  input  wire logic             meas_diff,
  input  wire logic             mrt_expired,
  input  wire logic             mod_active,
  input  wire logic [7:0]       depth_meas,
  output logic                  osc_on,
  output logic                  regulators_on,
  output logic                  rx_enable,
  output logic                  tx_enable,
  output logic                  rc_osc_on,
  output logic                  meas_start,
  output logic                  irq,
  output rfoc_pkg::rfoc_drv_t   driver_output_one,
  output rfoc_pkg::rfoc_drv_t   driver_output_two,
  output logic [7:0]            rf_driver_supply,
  output logic                  am_chan_on,
  output logic                  pm_chan_on,
  output logic                  chan_auto,
  output logic                  chan_pm_manual,
  output logic                  rx_window,
  output logic                  rssi_agc_en,
  output logic                  framing_rx_en
);

  typedef enum logic [2:0] {
    RFOC_CAL_IDLE  = 3'b001,
    RFOC_CAL_TRY   = 3'b010,
    RFOC_CAL_JUDGE = 3'b100
  } rfoc_cal_t;

  localparam int RAMP_W = $clog2(rfoc_pkg::RAMP_STEP_CYC + 1);
  localparam int SETL_W = $clog2(rfoc_pkg::CAL_SETTLE_CYC + 1);
  localparam int WAKE_W = $clog2(WAKE_PERIOD + 1);

  logic [7:0] op_reg;
  logic [7:0] io1_reg;
  logic [7:0] io2_reg;
  logic [7:0] aux_reg;
  logic [7:0] mode_reg;
  logic [7:0] norm_reg;
  logic [7:0] am_reg;
  logic [7:0] depth_reg;
  logic [7:0] status_reg;
  logic [7:0] status_next;

  // two-stage synchronisers for analog pins
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic       osc_s;
  logic       car_s;
  logic       done_s;
  logic       diff_s;
  logic       mrt_s;
  logic       done_d_reg;
  logic       osc_d_reg;
  logic       mrt_d_reg;

  logic       wr_cmd;
  logic       cmd_preset;
  logic       cmd_mask;
  logic       cmd_unmask;
  logic       cmd_cal;
  logic       wake_mode;
  logic       osc_rise;
  logic       wake_hit;
  logic       cal_done;
  logic       status_rd;

  assign osc_s  = sync2_reg[0];
  assign car_s  = sync2_reg[1];
  assign done_s = sync2_reg[2];
  assign diff_s = sync2_reg[3];
  assign mrt_s  = sync2_reg[4];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {mrt_expired, meas_diff, meas_done, carrier_in,
                    osc_stable};
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done_d_reg <= 1'b0;
      osc_d_reg  <= 1'b0;
      mrt_d_reg  <= 1'b0;
    end else begin
      done_d_reg <= done_s;
      osc_d_reg  <= osc_s;
      mrt_d_reg  <= mrt_s;
    end
  end

  // direct commands are writes to the command address
  assign wr_cmd     = reg_we && (reg_addr == rfoc_pkg::ADDR_CMD);
  assign cmd_preset = wr_cmd && (reg_wdata == rfoc_pkg::CMD_PRESET);
  assign cmd_mask   = wr_cmd && (reg_wdata == rfoc_pkg::CMD_MASK);
  assign cmd_unmask = wr_cmd && (reg_wdata == rfoc_pkg::CMD_UNMASK);
  assign cmd_cal    = wr_cmd && (reg_wdata == rfoc_pkg::CMD_CAL);

  // configuration registers, writable in every mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      op_reg    <= rfoc_pkg::RST_OP;
      io1_reg   <= rfoc_pkg::RST_IO1;
      io2_reg   <= rfoc_pkg::RST_IO2;
      mode_reg  <= rfoc_pkg::RST_MODE;
      norm_reg  <= rfoc_pkg::RST_NORM;
      depth_reg <= rfoc_pkg::RST_DEPTH;
    end else if (reg_we) begin
      unique case (reg_addr)
        rfoc_pkg::ADDR_OP_CTRL: op_reg    <= reg_wdata;
        rfoc_pkg::ADDR_IO_CFG1: io1_reg   <= reg_wdata;
        rfoc_pkg::ADDR_IO_CFG2: io2_reg   <= reg_wdata;
        rfoc_pkg::ADDR_MODE:    mode_reg  <= reg_wdata;
        rfoc_pkg::ADDR_NORM:    norm_reg  <= reg_wdata;
        rfoc_pkg::ADDR_DEPTH:   depth_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // auxiliary register; analog preset picks the modulation type
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aux_reg <= rfoc_pkg::RST_AUX;
    end else if (reg_we && reg_addr == rfoc_pkg::ADDR_AUX_DEF) begin
      aux_reg <= reg_wdata;
    end else if (cmd_preset) begin
      if (mode_reg[1:0] == rfoc_pkg::MODE_OOK) begin
        aux_reg[rfoc_pkg::AUX_MODTYPE] <= 1'b0;
      end else if (mode_reg[1:0] == rfoc_pkg::MODE_AM) begin
        aux_reg[rfoc_pkg::AUX_MODTYPE] <= 1'b1;
      end
    end
  end

  // power and path enables
  assign osc_on        = op_reg[rfoc_pkg::OP_OSC_EN];
  assign regulators_on = op_reg[rfoc_pkg::OP_OSC_EN];
  assign rx_enable     = op_reg[rfoc_pkg::OP_RX_EN];
  assign tx_enable     = op_reg[rfoc_pkg::OP_TX_EN];

  // wake-up mode only with the wake bit alone
  assign wake_mode = (op_reg == (8'h01 << rfoc_pkg::OP_WAKE));
  assign rc_osc_on = wake_mode;

  // wake-up timer schedules periodic measurements
  logic [WAKE_W-1:0] wake_cnt_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt_reg <= '0;
      meas_start   <= 1'b0;
    end else if (!wake_mode) begin
      wake_cnt_reg <= '0;
      meas_start   <= 1'b0;
    end else if (wake_cnt_reg == WAKE_W'(WAKE_PERIOD - 1)) begin
      wake_cnt_reg <= '0;
      meas_start   <= 1'b1;
    end else begin
      wake_cnt_reg <= wake_cnt_reg + 1'b1;
      meas_start   <= 1'b0;
    end
  end

  // interrupt events
  assign osc_rise = osc_s && !osc_d_reg && osc_on;
  assign wake_hit = wake_mode && done_s && !done_d_reg && diff_s;
  assign status_rd = reg_re && (reg_addr == rfoc_pkg::ADDR_STATUS);

  // status clears on read; a new event in the same cycle wins
  always_comb begin
    status_next = status_rd ? 8'h00 : status_reg;
    if (osc_rise) begin
      status_next[rfoc_pkg::ST_OSC] = 1'b1;
    end
    if (wake_hit) begin
      status_next[rfoc_pkg::ST_WAKE] = 1'b1;
    end
    if (cal_done) begin
      status_next[rfoc_pkg::ST_CAL] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= 8'h00;
    end else begin
      status_reg <= status_next;
    end
  end

  assign irq = |status_reg;

  // read data one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_re) begin
      unique case (reg_addr)
        rfoc_pkg::ADDR_OP_CTRL: reg_rdata <= op_reg;
        rfoc_pkg::ADDR_IO_CFG1: reg_rdata <= io1_reg;
        rfoc_pkg::ADDR_IO_CFG2: reg_rdata <= io2_reg;
        rfoc_pkg::ADDR_AUX_DEF: reg_rdata <= aux_reg;
        rfoc_pkg::ADDR_MODE:    reg_rdata <= mode_reg;
        rfoc_pkg::ADDR_NORM:    reg_rdata <= norm_reg;
        rfoc_pkg::ADDR_AM_LVL:  reg_rdata <= am_reg;
        rfoc_pkg::ADDR_DEPTH:   reg_rdata <= depth_reg;
        rfoc_pkg::ADDR_STATUS:  reg_rdata <= status_reg;
        default:                reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // am level: written directly or trimmed by successive approximation
  rfoc_cal_t        cal_reg;
  logic [2:0]       cal_bit_reg;
  logic [SETL_W-1:0] setl_reg;

  assign cal_done = (cal_reg == RFOC_CAL_JUDGE) && (setl_reg == '0)
                    && (cal_bit_reg == 3'h0);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cal_reg     <= RFOC_CAL_IDLE;
      cal_bit_reg <= 3'h7;
      setl_reg    <= '0;
      am_reg      <= rfoc_pkg::RST_AM;
    end else begin
      unique case (cal_reg)
        RFOC_CAL_IDLE: begin
          if (cmd_cal) begin
            am_reg      <= 8'h00;
            cal_bit_reg <= 3'h7;
            cal_reg     <= RFOC_CAL_TRY;
          end else if (reg_we && reg_addr == rfoc_pkg::ADDR_AM_LVL) begin
            am_reg <= reg_wdata;
          end
        end
        RFOC_CAL_TRY: begin
          am_reg[cal_bit_reg] <= 1'b1;
          setl_reg <= SETL_W'(rfoc_pkg::CAL_SETTLE_CYC);
          cal_reg  <= RFOC_CAL_JUDGE;
        end
        RFOC_CAL_JUDGE: begin
          if (setl_reg != '0) begin
            setl_reg <= setl_reg - 1'b1;
          end else begin
            // more segments give less depth; drop the bit if too shallow
            if (depth_meas < depth_reg) begin
              am_reg[cal_bit_reg] <= 1'b0;
            end
            if (cal_bit_reg == 3'h0) begin
              cal_reg <= RFOC_CAL_IDLE;
            end else begin
              cal_bit_reg <= cal_bit_reg - 1'b1;
              cal_reg     <= RFOC_CAL_TRY;
            end
          end
        end
      endcase
    end
  end

  // slow ramp of the driver supply
  logic [RAMP_W-1:0] ramp_cnt_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rf_driver_supply <= 8'hff;
      ramp_cnt_reg     <= '0;
    end else if (!io2_reg[rfoc_pkg::IO2_SLOW]) begin
      rf_driver_supply <= 8'hff;
      ramp_cnt_reg     <= '0;
    end else if (!tx_enable) begin
      rf_driver_supply <= 8'h00;
      ramp_cnt_reg     <= '0;
    end else if (rf_driver_supply != 8'hff) begin
      if (ramp_cnt_reg == RAMP_W'(rfoc_pkg::RAMP_STEP_CYC - 1)) begin
        ramp_cnt_reg     <= '0;
        rf_driver_supply <= rf_driver_supply + 8'h01;
      end else begin
        ramp_cnt_reg <= ramp_cnt_reg + 1'b1;
      end
    end
  end

  // driver control
  logic       ook_mode;
  logic       mod_ook;
  logic       mod_am;
  logic       hold_reg;
  logic       level_one;
  logic [7:0] seg_now;
  logic       single;
  logic       use_two;

  assign ook_mode = !aux_reg[rfoc_pkg::AUX_MODTYPE];
  assign mod_ook  = mod_active && ook_mode;
  assign mod_am   = mod_active && !ook_mode;
  assign single   = io1_reg[rfoc_pkg::IO1_SINGLE];
  assign use_two  = io1_reg[rfoc_pkg::IO1_OUTSEL];

  // remember the carrier phase until ook modulation freezes it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= 1'b0;
    end else if (!mod_ook) begin
      hold_reg <= car_s;
    end
  end

  assign level_one = mod_ook ? hold_reg : car_s;
  assign seg_now   = mod_am ? am_reg : norm_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      driver_output_one <= '0;
      driver_output_two <= '0;
    end else begin
      driver_output_one.seg   <= seg_now;
      driver_output_two.seg   <= seg_now;
      driver_output_one.level <= level_one;
      driver_output_two.level <= single ? level_one : !level_one;
      driver_output_one.oe    <= tx_enable
                                 && !(mod_ook && aux_reg[rfoc_pkg::AUX_FASTOOK])
                                 && !(single && use_two);
      driver_output_two.oe    <= tx_enable
                                 && !(mod_ook && aux_reg[rfoc_pkg::AUX_FASTOOK])
                                 && !(single && !use_two);
    end
  end

  // demodulation channel selection
  logic both_ch;
  assign both_ch = op_reg[rfoc_pkg::OP_RX_CHN];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      am_chan_on     <= 1'b0;
      pm_chan_on     <= 1'b0;
      chan_auto      <= 1'b0;
      chan_pm_manual <= 1'b0;
    end else begin
      am_chan_on <= rx_enable && (both_ch
                    || !aux_reg[rfoc_pkg::AUX_CHSEL]);
      pm_chan_on <= rx_enable && (both_ch
                    || aux_reg[rfoc_pkg::AUX_CHSEL]);
      chan_auto  <= rx_enable && both_ch
                    && !op_reg[rfoc_pkg::OP_RX_MAN];
      chan_pm_manual <= aux_reg[rfoc_pkg::AUX_CHSEL]
                    && !(both_ch && !op_reg[rfoc_pkg::OP_RX_MAN]);
    end
  end

  // receive window
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_window <= 1'b0;
    end else if (cmd_mask) begin
      rx_window <= 1'b0;
    end else if (cmd_unmask) begin
      rx_window <= 1'b1;
    end else if (mrt_s && !mrt_d_reg) begin
      rx_window <= 1'b1;
    end
  end

  assign rssi_agc_en   = rx_window && rx_enable;
  assign framing_rx_en = rx_window && rx_enable;

endmodule

`default_nettype wire

// >>> verification/rfoc_core_asserts.sv
// rfoc_core_asserts: port checks for the rf mode control block.
// assumes it is bound into rfoc_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module rfoc_core_asserts #(
  parameter int WAKE_PERIOD = 16
) (
  input wire logic                mclk,
  input wire logic                rst_n,
  input wire logic [5:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_we,
  input wire logic                reg_re,
  input wire logic [7:0]          reg_rdata,
  input wire logic                osc_stable,
  input wire logic                mrt_expired,
  input wire logic                osc_on,
  input wire logic                regulators_on,
  input wire logic                rx_enable,
  input wire logic                tx_enable,
  input wire logic                rc_osc_on,
  input wire logic                meas_start,
  input wire logic                irq,
  input wire rfoc_pkg::rfoc_drv_t driver_output_one,
  input wire rfoc_pkg::rfoc_drv_t driver_output_two,
  input wire logic [7:0]          rf_driver_supply,
  input wire logic                rx_window,
  input wire logic                rssi_agc_en,
  input wire logic                framing_rx_en
);
  logic [1:0]  sgl_h;
  logic [1:0]  ok_h;
  logic [15:0] gap;
  logic        had;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // io1 single bit history: drivers lag the register by one cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sgl_h <= 2'h0;
      ok_h  <= 2'h0;
    end else begin
      if (reg_we && reg_addr == rfoc_pkg::ADDR_IO_CFG1) begin
        sgl_h[0] <= reg_wdata[rfoc_pkg::IO1_SINGLE];
      end
      sgl_h[1] <= sgl_h[0];
      ok_h     <= {ok_h[0], 1'b1};
    end
  end

  // cycles since the last measurement pulse within one wake-up stay
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 16'h0000;
      had <= 1'b0;
    end else begin
      gap <= meas_start ? 16'h0000 : gap + 16'h0001;
      had <= rc_osc_on && (had || meas_start);
    end
  end

  sequence s_opw;
    reg_we && reg_addr == rfoc_pkg::ADDR_OP_CTRL;
  endsequence

  sequence s_cmd(logic [7:0] c);
    reg_we && reg_addr == rfoc_pkg::ADDR_CMD && reg_wdata == c;
  endsequence

  osc_enable_a:
    assert property (s_opw |=> osc_on == $past(reg_wdata[7])
                     && regulators_on == osc_on)
    else $error("oscillator enable does not follow op write");
  rx_tx_split_a:
    assert property (s_opw |=> rx_enable == $past(reg_wdata[6])
                     && tx_enable == $past(reg_wdata[3]))
    else $error("rx or tx enable does not follow op write");
  wake_entry_a:
    assert property (s_opw |=> rc_osc_on == ($past(reg_wdata) == 8'h04))
    else $error("wake mode entry wrong");
  wake_period_a:
    assert property (meas_start && had |-> gap == WAKE_PERIOD - 1)
    else $error("measurement period wrong");
  osc_irq_a:
    assert property ($rose(osc_stable) && osc_on |-> ##[1:5] irq)
    else $error("no interrupt after oscillator stable");
  mask_cmd_a:
    assert property (s_cmd(rfoc_pkg::CMD_MASK) |=> !rx_window)
    else $error("mask command left window open");
  unmask_cmd_a:
    assert property (s_cmd(rfoc_pkg::CMD_UNMASK) |=> rx_window)
    else $error("unmask command left window closed");
  mrt_open_a:
    assert property ($rose(mrt_expired) && !reg_we |-> ##[1:5] rx_window)
    else $error("window not opened after mask timer");
  window_gate_a:
    assert property (rssi_agc_en == (rx_window && rx_enable)
                     && framing_rx_en == rssi_agc_en)
    else $error("receive gating wrong");
  tx_off_a:
    assert property (!tx_enable ##1 !tx_enable |->
                     !driver_output_one.oe && !driver_output_two.oe)
    else $error("driver enabled with tx off");
  diff_level_a:
    assert property (ok_h[1] && sgl_h == 2'h0 |->
                     driver_output_one.level != driver_output_two.level)
    else $error("differential levels not opposite");
  single_oe_a:
    assert property (ok_h[1] && sgl_h == 2'h3 |->
                     !(driver_output_one.oe && driver_output_two.oe))
    else $error("both drivers on in single mode");
  rdata_idle_a:
    assert property (!$past(reg_re) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule

bind rfoc_core rfoc_core_asserts #(.WAKE_PERIOD(WAKE_PERIOD)) u_chk (.*);

`default_nettype wire

// >>> verification/rfoc_core_tb.sv
// rfoc_core_tb: register-driven tests of the rf mode control block.
// assumes rfoc_host on the register port; the bench drives analog pins.
`timescale 1ns/1ps
`default_nettype none

module rfoc_core_tb;
  logic                mclk;
  logic                rst_n;
  logic [5:0]          reg_addr;
  logic [7:0]          reg_wdata, reg_rdata, depth_meas, rf_driver_supply;
  logic                reg_we, reg_re, osc_stable, carrier_in, meas_done;
  logic                meas_diff, mrt_expired, mod_active, osc_on, irq;
  logic                regulators_on, rx_enable, tx_enable, rc_osc_on;
  logic                meas_start, am_chan_on, pm_chan_on, chan_auto;
  logic                chan_pm_manual, rx_window, rssi_agc_en, framing_rx_en;
  logic                held;
  rfoc_pkg::rfoc_drv_t driver_output_one, driver_output_two;
  int                  err_total = 0;
  int                  num_checks = 0;
  int                  cyc = 0;
  int                  n;

  rfoc_core #(.WAKE_PERIOD(16)) DUT (.*);
  rfoc_host #(.HOLD_CYC(40)) u_host (.*);

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic s, input logic e);
    chk({7'h00, s}, {7'h00, e});
  endtask
  task automatic oes(input logic [7:0] e);
    chk({6'h00, driver_output_one.oe, driver_output_two.oe}, e);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_host.wr(a, d);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_host.rd(a, v);
    chk(v, e);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wait_irq(input int k);
    for (int i = 0; i < k && irq !== 1'b1; i++) tick(1);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // carrier toggles every cycle; cycle ceiling cuts a hang short
  always @(posedge mclk) begin
    carrier_in <= ~carrier_in;
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    rst_n = 1'b0;
    {osc_stable, carrier_in, meas_done, meas_diff} = 4'h0;
    {mrt_expired, mod_active} = 2'h0;
    depth_meas = 8'h00;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    tick(1);
    rchk(rfoc_pkg::ADDR_OP_CTRL, 8'h00);
    chk1(osc_on, 1'b0);
    rchk(rfoc_pkg::ADDR_NORM, 8'hff);
    rchk(rfoc_pkg::ADDR_AM_LVL, 8'h0f);
    rchk(rfoc_pkg::ADDR_DEPTH, 8'h80);
    rchk(6'h3f, 8'h00);
    wr(rfoc_pkg::ADDR_NORM, 8'h5a);
    rchk(rfoc_pkg::ADDR_NORM, 8'h5a);
    wr(rfoc_pkg::ADDR_STATUS, 8'hff);
    rchk(rfoc_pkg::ADDR_STATUS, 8'h00);
    wr(rfoc_pkg::ADDR_OP_CTRL, 8'h80);
    chk1(regulators_on, 1'b1);
    @(posedge mclk) osc_stable <= 1'b1;
    wait_irq(10);
    rchk(rfoc_pkg::ADDR_STATUS, 8'h01);
    chk1(irq, 1'b0);
    wr(rfoc_pkg::ADDR_OP_CTRL, 8'h88);
    chk1(rx_enable, 1'b0);
    wr(rfoc_pkg::ADDR_OP_CTRL, 8'he0);
    tick(1);
    chk1(tx_enable, 1'b0);
    chk1(am_chan_on && pm_chan_on, 1'b1);
    chk1(chan_auto, 1'b1);
    wr(rfoc_pkg::ADDR_OP_CTRL, 8'hf0);
    wr(rfoc_pkg::ADDR_AUX_DEF, 8'h08);
    tick(1);
    chk1(chan_auto, 1'b0);
    chk1(chan_pm_manual, 1'b1);
    wr(rfoc_pkg::ADDR_OP_CTRL, 8'hc0);
    tick(1);
    chk1(am_chan_on ^ pm_chan_on, 1'b1);
    wr(rfoc_pkg::ADDR_CMD, rfoc_pkg::CMD_UNMASK);
    tick(1);
    chk1(framing_rx_en, 1'b1);
    wr(rfoc_pkg::ADDR_CMD, rfoc_pkg::CMD_MASK);
    tick(1);
    chk1(rssi_agc_en, 1'b0);
    @(posedge mclk) mrt_expired <= 1'b1;
    tick(5);
    chk1(rx_window, 1'b1);
    @(posedge mclk) mrt_expired <= 1'b0;
    wr(rfoc_pkg::ADDR_OP_CTRL, 8'h04);
    chk1(rc_osc_on, 1'b1);
    for (int i = 0; i < 40 && meas_start !== 1'b1; i++) tick(1);
    chk1(meas_start, 1'b1);
    @(posedge mclk) {meas_diff, meas_done} <= 2'h3;
    tick(2);
    @(posedge mclk) meas_done <= 1'b0;
    wait_irq(10);
    rchk(rfoc_pkg::ADDR_STATUS, 8'h02);
    tick(20);
    wr(rfoc_pkg::ADDR_OP_CTRL, 8'h0c);
    chk1(rc_osc_on, 1'b0);
    n = 0;
    repeat (40) begin
      tick(1);
      if (meas_start !== 1'b0) n++;
    end
    chk(8'(n), 8'h00);
    for (int m = 0; m < 2; m++) begin
      wr(rfoc_pkg::ADDR_AUX_DEF, 8'h00);
      wr(rfoc_pkg::ADDR_MODE, m[7:0]);
      wr(rfoc_pkg::ADDR_CMD, rfoc_pkg::CMD_PRESET);
      tick(1);
      rchk(rfoc_pkg::ADDR_AUX_DEF, m ? 8'h20 : 8'h00);
    end
    wr(rfoc_pkg::ADDR_OP_CTRL, 8'h88);
    wr(rfoc_pkg::ADDR_IO_CFG1, 8'h00);
    tick(1);
    oes(8'h03);
    chk(driver_output_one.seg, 8'h5a);
    wr(rfoc_pkg::ADDR_IO_CFG1, 8'h80);
    tick(1);
    oes(8'h02);
    wr(rfoc_pkg::ADDR_IO_CFG1, 8'hc0);
    tick(1);
    oes(8'h01);
    wr(rfoc_pkg::ADDR_IO_CFG1, 8'h00);
    wr(rfoc_pkg::ADDR_AUX_DEF, 8'h00);
    @(posedge mclk) mod_active <= 1'b1;
    tick(2);
    held = driver_output_one.level;
    repeat (3) begin
      tick(1);
      chk1(driver_output_one.level, held);
    end
    wr(rfoc_pkg::ADDR_AUX_DEF, 8'h10);
    tick(1);
    oes(8'h00);
    wr(rfoc_pkg::ADDR_AUX_DEF, 8'h20);
    tick(1);
    chk(driver_output_one.seg, 8'h0f);
    @(posedge mclk) mod_active <= 1'b0;
    tick(2);
    chk(driver_output_one.seg, 8'h5a);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk) depth_meas <= k ? 8'h00 : 8'hff;
      wr(rfoc_pkg::ADDR_CMD, rfoc_pkg::CMD_CAL);
      tick(30);
      wr(rfoc_pkg::ADDR_AM_LVL, 8'h55);
      wait_irq(300);
      rchk(rfoc_pkg::ADDR_STATUS, 8'h04);
      rchk(rfoc_pkg::ADDR_AM_LVL, k ? 8'h00 : 8'hff);
    end
    wr(rfoc_pkg::ADDR_OP_CTRL, 8'h80);
    u_host.slow_prep();
    chk(rf_driver_supply, 8'h00);
    wr(rfoc_pkg::ADDR_OP_CTRL, 8'h88);
    tick(25);
    chk1(rf_driver_supply inside {[8'h01:8'h03]}, 1'b1);
    wr(rfoc_pkg::ADDR_IO_CFG2, 8'h00);
    tick(1);
    chk(rf_driver_supply, 8'hff);
    summarize();
  end
endmodule

`default_nettype wire

// >>> verification/rfoc_host.sv
// rfoc_host: controller model on the register port of the mode block.
// assumes its tasks are called just after a rising mclk edge.
`timescale 1ns/1ps
`default_nettype none

module rfoc_host #(
  parameter int HOLD_CYC = 250000
) (
  input wire logic       mclk,
  input wire logic [7:0] reg_rdata,
  output logic [5:0]     reg_addr,
  output logic [7:0]     reg_wdata,
  output logic           reg_we,
  output logic           reg_re
);
  initial begin
    reg_addr  = 6'h00;
    reg_wdata = 8'h00;
    reg_we    = 1'b0;
    reg_re    = 1'b0;
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge mclk);
    reg_we    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge mclk);
    reg_re   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // slow ramp bit goes up with tx off, then the supply is left to drain
  task automatic slow_prep();
    wr(rfoc_pkg::ADDR_IO_CFG2, 8'h80);
    repeat (HOLD_CYC) @(posedge mclk);
    #1;
  endtask
endmodule

`default_nettype wire
